// File: common/eeprom_cfg_pkg.sv
// Summary of operation
// [R1] A 512-byte array is programmed and erased by the internal charge pump.
// [R2] Every reset copies each non-volatile register into its volatile copy.
// [R3] The array configuration shadow is loaded from the option register at reset.
// [R4] The 11-bit divider pair loads its volatile high and low bytes at reset.
// [R5] Timebase divides crystal or bus clock by the divider, chosen by select.
// [R6] Software loads the divider as INT(fref * 35 us + 0.5) before operations.
// [R7] Security is enabled when the option security bit reads zero.
// [R8] Secured: the 16 bytes at the top of block one refuse program and erase.
// [R9] Secured: block and bulk erase refused; byte erase allowed outside secured bytes.
// [R10] Secured: the option register itself refuses program and erase.
// [R11] Four 128-byte blocks, each with a protect bit, bit zero lowest.
// [R12] Changed protect bits apply only after reset or option register read.
// [R13] Software programs or erases protect bits, then reads the option register.
// [R14] Non-volatile registers use the same program and erase sequence as array bytes.
// [R15] Program-go set is ignored without address latch or a valid latched address.
// [R16] Clearing program-go and address latch together clears only program-go.
// [R17] In automatic mode the internal timer clears program-go when done.
// [R18] Power-off bit powers the array down; reset clears it.
// [R19] Protected or secured targets get no high voltage and stay unchanged.
package eeprom_cfg_pkg;

    // ----------------------------------------------------------------
    // Address map
    // ----------------------------------------------------------------
    localparam logic [15:0] ARRAY_BASE = 16'h0800;
    localparam logic [15:0] ARRAY_LAST = 16'h09FF;
    localparam int ARRAY_BYTES = 512;
    localparam logic [8:0] SECURED_FIRST = 9'h0F0;
    localparam logic [8:0] SECURED_LAST = 9'h0FF;
    localparam logic [15:0] OFS_DIV_NV_HI = 16'hFE10;
    localparam logic [15:0] OFS_DIV_NV_LO = 16'hFE11;
    localparam logic [15:0] OFS_DIV_HI = 16'hFE1A;
    localparam logic [15:0] OFS_DIV_LO = 16'hFE1B;
    localparam logic [15:0] OFS_OPT_NV = 16'hFE1C;
    localparam logic [15:0] OFS_CTRL = 16'hFE1D;
    localparam logic [15:0] OFS_OPT_SHADOW = 16'hFE1F;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int CTL_PGM = 0;
    localparam int CTL_AUTO = 1;
    localparam int CTL_LAT = 2;
    localparam int CTL_RAS0 = 3;
    localparam int CTL_RAS1 = 4;
    localparam int CTL_OFF = 5;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hBF;
    localparam int OPT_SEC_BIT = 4;
    localparam int OPT_BP_MSB = 3;
    localparam logic [7:0] DIVH_WMASK = 8'h07;
    localparam int DIV_W = 11;
    localparam logic [7:0] ERASED = 8'hFF;

    typedef enum logic [1:0] {
        MODE_BYTE_PGM = 2'h0,
        MODE_BYTE_ERS = 2'h1,
        MODE_BLOCK_ERS = 2'h2,
        MODE_BULK_ERS = 2'h3
    } pe_mode_t;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int TB_PERIOD_US = 35;
    localparam int CLK_PERIOD_NS = 5;
    // Divider that gives the timebase when the bus clock is the reference
    localparam int TB_BUS_DIV = TB_PERIOD_US * 1000 / CLK_PERIOD_NS;
    localparam logic [7:0] TICKS_PGM = 8'h04;
    localparam logic [7:0] TICKS_BYTE_ERS = 8'h04;
    localparam logic [7:0] TICKS_BLOCK_ERS = 8'h08;
    localparam logic [7:0] TICKS_BULK_ERS = 8'h10;

endpackage

// File: verilog/ee_timebase_div.sv
`timescale 1ns/1ps
module ee_timebase_div #(
    parameter int DIV_W = 11
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic bus_sel_i,
    input wire logic xtal_i,
    input wire logic [DIV_W-1:0] divisor_i,
    output logic tick_o
);

    localparam logic [DIV_W-1:0] ONE = DIV_W'(1);

    logic xtal_q;
    logic ref_edge;
    logic last;
    logic [DIV_W-1:0] cnt;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xtal_q <= 1'b0;
        end else begin
            xtal_q <= xtal_i;
        end
    end

    // Reference is the bus clock itself or rising edges of the crystal level
    assign ref_edge = bus_sel_i || (xtal_i && !xtal_q); // [R5]
    // A divisor of zero behaves as one rather than stalling the timer
    assign last = (divisor_i <= ONE) || (cnt == divisor_i - ONE);

    // Counter restarts with each operation so the first period is whole
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt <= '0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (ref_edge) begin
                if (last) begin
                    cnt <= '0;
                    tick_o <= 1'b1; // [R5]
                end else begin
                    cnt <= cnt + ONE;
                end
            end
        end
    end

endmodule

// File: verilog/eeprom_config_protect_ctrl.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module eeprom_config_protect_ctrl #(
    parameter logic [7:0] PGM_TICKS = eeprom_cfg_pkg::TICKS_PGM,
    parameter logic [7:0] BYTE_ERS_TICKS = eeprom_cfg_pkg::TICKS_BYTE_ERS,
    parameter logic [7:0] BLOCK_ERS_TICKS = eeprom_cfg_pkg::TICKS_BLOCK_ERS,
    parameter logic [7:0] BULK_ERS_TICKS = eeprom_cfg_pkg::TICKS_BULK_ERS
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [15:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic XTAL_REF_I,
    input wire logic TB_CLK_SEL_I,
    output logic HV_EN_O,
    output logic ARRAY_PWR_DOWN_O,
    output logic SECURE_O
);

    // ----------------------------------------------------------------
    // Storage and state
    // ----------------------------------------------------------------
    // Non-volatile cells carry no reset: they survive it by nature
    // Blank registers start erased so security never decodes as unknown
    logic [7:0] mem [0:eeprom_cfg_pkg::ARRAY_BYTES-1];
    logic [7:0] opt_nv = eeprom_cfg_pkg::ERASED;
    logic [7:0] div_nv_hi = eeprom_cfg_pkg::ERASED;
    logic [7:0] div_nv_lo = eeprom_cfg_pkg::ERASED;

    logic [7:0] opt_shadow;
    logic [7:0] div_hi;
    logic [7:0] div_lo;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [7:0] rdata;
    logic [7:0] rd_val;
    logic [15:0] lat_addr;
    logic [7:0] lat_data;
    logic lat_valid;
    logic pgm_d;
    logic hv;
    logic tick;
    logic [7:0] tcnt;
    logic [7:0] need;
    logic [7:0] cur;
    logic [7:0] byte_new;
    logic op_ok;
    logic sec;
    logic pgm_start;
    logic done_auto;
    logic commit;
    logic [1:0] mode;
    logic [8:0] lat_idx;
    logic [8:0] rd_idx;
    logic [1:0] lat_blk;
    logic lat_in_array;
    logic wr_ctrl;
    logic wr_div_hi;
    logic wr_div_lo;
    logic rd_opt_nv;

    function automatic logic in_array(input logic [15:0] a);
        in_array = (a >= eeprom_cfg_pkg::ARRAY_BASE) && (a <= eeprom_cfg_pkg::ARRAY_LAST);
    endfunction

    function automatic logic nv_reg(input logic [15:0] a);
        nv_reg = (a == eeprom_cfg_pkg::OFS_OPT_NV) || (a == eeprom_cfg_pkg::OFS_DIV_NV_HI)
            || (a == eeprom_cfg_pkg::OFS_DIV_NV_LO);
    endfunction

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    assign wr_ctrl = WR_I && (ADDR_I == eeprom_cfg_pkg::OFS_CTRL);
    assign wr_div_hi = WR_I && (ADDR_I == eeprom_cfg_pkg::OFS_DIV_HI);
    assign wr_div_lo = WR_I && (ADDR_I == eeprom_cfg_pkg::OFS_DIV_LO);
    assign rd_opt_nv = RD_I && (ADDR_I == eeprom_cfg_pkg::OFS_OPT_NV);
    assign mode = ctrl[eeprom_cfg_pkg::CTL_RAS1:eeprom_cfg_pkg::CTL_RAS0];
    assign lat_idx = 9'(lat_addr - eeprom_cfg_pkg::ARRAY_BASE);
    assign rd_idx = 9'(ADDR_I - eeprom_cfg_pkg::ARRAY_BASE);
    assign lat_blk = lat_idx[8:7];
    assign lat_in_array = in_array(lat_addr);
    assign sec = !opt_shadow[eeprom_cfg_pkg::OPT_SEC_BIT]; // [R7]

    // ----------------------------------------------------------------
    // Control register
    // ----------------------------------------------------------------
    always_comb begin
        next_ctrl = WDATA_I & eeprom_cfg_pkg::CTRL_WMASK;
        if (ctrl[eeprom_cfg_pkg::CTL_PGM]) begin
            // Mode is frozen and the latch held while high voltage may be on
            next_ctrl[eeprom_cfg_pkg::CTL_RAS1:eeprom_cfg_pkg::CTL_RAS0] = mode;
            next_ctrl[eeprom_cfg_pkg::CTL_LAT] = ctrl[eeprom_cfg_pkg::CTL_LAT]; // [R16]
        end else if (!(ctrl[eeprom_cfg_pkg::CTL_LAT] && lat_valid
            && WDATA_I[eeprom_cfg_pkg::CTL_LAT])) begin
            next_ctrl[eeprom_cfg_pkg::CTL_PGM] = 1'b0; // [R15]
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ctrl <= eeprom_cfg_pkg::CTRL_RST; // [R18]
        end else if (done_auto) begin
            ctrl[eeprom_cfg_pkg::CTL_PGM] <= 1'b0; // [R17]
        end else if (wr_ctrl) begin
            ctrl <= next_ctrl;
        end
    end

    // ----------------------------------------------------------------
    // Address and data latch
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            lat_valid <= 1'b0;
            lat_addr <= 16'h0000;
            lat_data <= 8'h00;
        end else if (!ctrl[eeprom_cfg_pkg::CTL_LAT]) begin
            lat_valid <= 1'b0;
        end else if (!ctrl[eeprom_cfg_pkg::CTL_PGM]) begin
            if (WR_I && (in_array(ADDR_I) || nv_reg(ADDR_I))) begin
                lat_addr <= ADDR_I;
                lat_data <= WDATA_I;
                lat_valid <= 1'b1;
            end else if (RD_I && lat_valid && in_array(ADDR_I)) begin
                // An array read while latched moves the latched address
                lat_addr <= ADDR_I;
            end
        end
    end

    // ----------------------------------------------------------------
    // Protection check
    // ----------------------------------------------------------------
    always_comb begin
        op_ok = 1'b0;
        if (lat_in_array) begin
            unique case (mode)
                eeprom_cfg_pkg::MODE_BYTE_PGM, eeprom_cfg_pkg::MODE_BYTE_ERS: begin
                    op_ok = !opt_shadow[lat_blk] // [R11]
                        && !(sec && lat_idx >= eeprom_cfg_pkg::SECURED_FIRST
                        && lat_idx <= eeprom_cfg_pkg::SECURED_LAST); // [R8]
                end
                eeprom_cfg_pkg::MODE_BLOCK_ERS: begin
                    op_ok = !sec && !opt_shadow[lat_blk]; // [R9] [R11]
                end
                eeprom_cfg_pkg::MODE_BULK_ERS: begin
                    op_ok = !sec && (opt_shadow[eeprom_cfg_pkg::OPT_BP_MSB:0] == 4'h0); // [R9]
                end
            endcase
        end else if (lat_addr == eeprom_cfg_pkg::OFS_OPT_NV) begin
            op_ok = !sec && !mode[1]; // [R10] [R14]
        end else if (nv_reg(lat_addr)) begin
            op_ok = !mode[1]; // [R14]
        end
    end

    // ----------------------------------------------------------------
    // Sequencing and timebase
    // ----------------------------------------------------------------
    assign pgm_start = ctrl[eeprom_cfg_pkg::CTL_PGM] && !pgm_d;
    assign commit = hv && !ctrl[eeprom_cfg_pkg::CTL_PGM];

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            pgm_d <= 1'b0;
        end else begin
            pgm_d <= ctrl[eeprom_cfg_pkg::CTL_PGM];
        end
    end

    // Refused targets never see the pump; the go bit still stands for software
    always_ff @(posedge CLK_I) begin
        if (RST_I || !ctrl[eeprom_cfg_pkg::CTL_PGM]) begin
            hv <= 1'b0;
        end else if (pgm_start && op_ok && !ctrl[eeprom_cfg_pkg::CTL_OFF]) begin
            hv <= 1'b1; // [R19] [R1]
        end
    end

    always_comb begin
        unique case (mode)
            eeprom_cfg_pkg::MODE_BYTE_PGM: need = PGM_TICKS;
            eeprom_cfg_pkg::MODE_BYTE_ERS: need = BYTE_ERS_TICKS;
            eeprom_cfg_pkg::MODE_BLOCK_ERS: need = BLOCK_ERS_TICKS;
            eeprom_cfg_pkg::MODE_BULK_ERS: need = BULK_ERS_TICKS;
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I || !hv) begin
            tcnt <= 8'h00;
        end else if (tick && tcnt != 8'hFF) begin
            tcnt <= tcnt + 8'h01;
        end
    end

    assign done_auto = hv && ctrl[eeprom_cfg_pkg::CTL_AUTO] && ctrl[eeprom_cfg_pkg::CTL_PGM]
        && tick && (tcnt == need - 8'h01); // [R17]

    // Divider value is trusted as loaded by software before the operation
    ee_timebase_div #(
        .DIV_W(eeprom_cfg_pkg::DIV_W)
    ) u_timebase (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .run_i(hv),
        .bus_sel_i(TB_CLK_SEL_I),
        .xtal_i(XTAL_REF_I),
        .divisor_i({div_hi[2:0], div_lo}), // [R5] [R6]
        .tick_o(tick)
    );

    // ----------------------------------------------------------------
    // Array and non-volatile registers
    // ----------------------------------------------------------------
    always_comb begin
        cur = eeprom_cfg_pkg::ERASED;
        if (lat_in_array) begin
            cur = mem[lat_idx];
        end else if (lat_addr == eeprom_cfg_pkg::OFS_OPT_NV) begin
            cur = opt_nv;
        end else if (lat_addr == eeprom_cfg_pkg::OFS_DIV_NV_HI) begin
            cur = div_nv_hi;
        end else if (lat_addr == eeprom_cfg_pkg::OFS_DIV_NV_LO) begin
            cur = div_nv_lo;
        end
        // Programming can only pull bits to zero
        byte_new = (mode == eeprom_cfg_pkg::MODE_BYTE_PGM) ? (cur & lat_data)
            : eeprom_cfg_pkg::ERASED;
    end

    always_ff @(posedge CLK_I) begin
        if (commit && lat_in_array) begin
            for (int i = 0; i < eeprom_cfg_pkg::ARRAY_BYTES; i++) begin
                if ((mode == eeprom_cfg_pkg::MODE_BULK_ERS)
                    || (mode == eeprom_cfg_pkg::MODE_BLOCK_ERS && 2'(i >> 7) == lat_blk)) begin
                    mem[i] <= eeprom_cfg_pkg::ERASED; // [R1] [R11]
                end
            end
            if (!mode[1]) begin
                mem[lat_idx] <= byte_new; // [R1]
            end
        end
    end

    // Block and bulk erase never reach these cells
    always_ff @(posedge CLK_I) begin
        if (commit && !mode[1]) begin
            if (lat_addr == eeprom_cfg_pkg::OFS_OPT_NV) begin
                opt_nv <= byte_new; // [R14]
            end
            if (lat_addr == eeprom_cfg_pkg::OFS_DIV_NV_HI) begin
                div_nv_hi <= byte_new; // [R14]
            end
            if (lat_addr == eeprom_cfg_pkg::OFS_DIV_NV_LO) begin
                div_nv_lo <= byte_new; // [R14]
            end
        end
    end

    // ----------------------------------------------------------------
    // Volatile copies
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            opt_shadow <= opt_nv; // [R2] [R3]
            div_hi <= div_nv_hi; // [R2] [R4]
            div_lo <= div_nv_lo; // [R4]
        end else begin
            if (rd_opt_nv) begin
                opt_shadow[eeprom_cfg_pkg::OPT_BP_MSB:0] <= opt_nv[eeprom_cfg_pkg::OPT_BP_MSB:0]; // [R12]
            end
            if (wr_div_hi) begin
                div_hi <= (div_hi & ~eeprom_cfg_pkg::DIVH_WMASK)
                    | (WDATA_I & eeprom_cfg_pkg::DIVH_WMASK);
            end
            if (wr_div_lo) begin
                div_lo <= WDATA_I;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always_comb begin
        rd_val = 8'h00;
        if (in_array(ADDR_I)) begin
            if (ctrl[eeprom_cfg_pkg::CTL_OFF]) begin
                rd_val = 8'h00; // [R18]
            end else if (ctrl[eeprom_cfg_pkg::CTL_LAT] && lat_valid) begin
                rd_val = lat_data;
            end else begin
                rd_val = mem[rd_idx];
            end
        end else begin
            case (ADDR_I)
                eeprom_cfg_pkg::OFS_DIV_NV_HI: rd_val = div_nv_hi;
                eeprom_cfg_pkg::OFS_DIV_NV_LO: rd_val = div_nv_lo;
                eeprom_cfg_pkg::OFS_DIV_HI: rd_val = div_hi;
                eeprom_cfg_pkg::OFS_DIV_LO: rd_val = div_lo;
                eeprom_cfg_pkg::OFS_OPT_NV: rd_val = opt_nv;
                eeprom_cfg_pkg::OFS_CTRL: rd_val = ctrl;
                eeprom_cfg_pkg::OFS_OPT_SHADOW: rd_val = opt_shadow;
                default: rd_val = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rdata <= 8'h00;
        end else begin
            rdata <= RD_I ? rd_val : 8'h00;
        end
    end

    assign RDATA_O = rdata;
    assign HV_EN_O = hv;
    assign ARRAY_PWR_DOWN_O = ctrl[eeprom_cfg_pkg::CTL_OFF]; // [R18]
    assign SECURE_O = sec;
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_reset_copies: assert property ($past(RST_I) |-> opt_shadow == $past(opt_nv) // [R2] [R3] [R4]
        && {div_hi, div_lo} == {$past(div_nv_hi), $past(div_nv_lo)})
        else $error("volatile copies not loaded at reset");
    a_go_needs_latch: assert property ($rose(ctrl[eeprom_cfg_pkg::CTL_PGM]) |-> // [R15]
        $past(ctrl[eeprom_cfg_pkg::CTL_LAT]) && $past(lat_valid))
        else $error("program-go set without a valid latch");
    a_dual_clear_lat: assert property (ctrl[eeprom_cfg_pkg::CTL_PGM] && wr_ctrl // [R16]
        && !WDATA_I[eeprom_cfg_pkg::CTL_PGM] && !WDATA_I[eeprom_cfg_pkg::CTL_LAT]
        |=> !ctrl[eeprom_cfg_pkg::CTL_PGM] && ctrl[eeprom_cfg_pkg::CTL_LAT])
        else $error("latch cleared together with program-go");
    a_auto_clear: assert property (done_auto |=> !ctrl[eeprom_cfg_pkg::CTL_PGM] ##1 !hv) // [R17]
        else $error("automatic completion did not end the operation");
    a_hv_allowed: assert property ($rose(hv) |-> $past(op_ok) && $past(pgm_start)) // [R19]
        else $error("high voltage on a refused target");
    a_secured_bytes: assert property (hv && sec && lat_in_array |-> // [R8]
        !(lat_idx >= eeprom_cfg_pkg::SECURED_FIRST && lat_idx <= eeprom_cfg_pkg::SECURED_LAST))
        else $error("secured bytes under high voltage");
    a_secure_erase: assert property (hv && sec |-> !mode[1]) // [R9]
        else $error("block or bulk erase while secured");
    a_option_locked: assert property (hv && sec |-> lat_addr != eeprom_cfg_pkg::OFS_OPT_NV) // [R10]
        else $error("option register altered while secured");
    a_block_protect: assert property (hv && lat_in_array && !mode[1] |-> !opt_shadow[lat_blk]) // [R11]
        else $error("protected block under high voltage");
    a_protect_apply: assert property (rd_opt_nv |=> // [R12]
        opt_shadow[eeprom_cfg_pkg::OPT_BP_MSB:0] == $past(opt_nv[eeprom_cfg_pkg::OPT_BP_MSB:0]))
        else $error("protect bits not refreshed by option read");
    a_nv_program: assert property (commit && mode == eeprom_cfg_pkg::MODE_BYTE_PGM // [R14]
        && lat_addr == eeprom_cfg_pkg::OFS_OPT_NV |=> opt_nv == $past(opt_nv & lat_data))
        else $error("option register not programmed like an array byte");
    a_power_off: assert property (ctrl[eeprom_cfg_pkg::CTL_OFF] && !hv |=> !$rose(hv)) // [R18]
        else $error("high voltage started while array powered off");
    a_read_slot: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
        else $error("read data outside its slot");
    c_auto_done: cover property (done_auto);
    c_manual_commit: cover property (commit && !ctrl[eeprom_cfg_pkg::CTL_AUTO]);
    c_refused: cover property (pgm_start && !op_ok);
    c_block_erase: cover property (commit && mode == eeprom_cfg_pkg::MODE_BLOCK_ERS);
endmodule

// File: tb/eeprom_config_protect_ctrl_tb_top.sv
`timescale 1ns/1ps
module eeprom_config_protect_ctrl_tb_top;
    localparam logic [15:0] CT = eeprom_cfg_pkg::OFS_CTRL;
    localparam logic [15:0] OPT = eeprom_cfg_pkg::OFS_OPT_NV;
    localparam logic [15:0] SHD = eeprom_cfg_pkg::OFS_OPT_SHADOW;
    localparam int T_PGM = int'(eeprom_cfg_pkg::TICKS_PGM);
    localparam int T_ERS = int'(eeprom_cfg_pkg::TICKS_BYTE_ERS);
    logic CLK_I = 1'b0;
    logic RST_I = 1'b1;
    logic [15:0] ADDR_I = 16'h0000;
    logic [7:0] WDATA_I = 8'h00;
    logic WR_I = 1'b0;
    logic RD_I = 1'b0;
    logic XTAL_REF_I = 1'b0;
    logic TB_CLK_SEL_I = 1'b0;
    logic [7:0] RDATA_O;
    logic HV_EN_O;
    logic ARRAY_PWR_DOWN_O;
    logic SECURE_O;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int hv_cnt = 0;
    logic [7:0] d;
    logic ok;

    eeprom_config_protect_ctrl dut_u (
        .CLK_I(CLK_I),
        .RST_I(RST_I),
        .ADDR_I(ADDR_I),
        .WDATA_I(WDATA_I),
        .WR_I(WR_I),
        .RD_I(RD_I),
        .RDATA_O(RDATA_O),
        .XTAL_REF_I(XTAL_REF_I),
        .TB_CLK_SEL_I(TB_CLK_SEL_I),
        .HV_EN_O(HV_EN_O),
        .ARRAY_PWR_DOWN_O(ARRAY_PWR_DOWN_O),
        .SECURE_O(SECURE_O)
    );

    always #2.5 CLK_I = ~CLK_I;

    // --------------------------------------------------------------
    // Stimulus helpers
    // --------------------------------------------------------------
    task automatic report_and_stop();
        if (fail_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Crystal reference gives one rising edge every two bus cycles
    always @(posedge CLK_I) begin
        XTAL_REF_I <= ~XTAL_REF_I;
        cycles <= cycles + 1;
        if (HV_EN_O === 1'b1) hv_cnt <= hv_cnt + 1;
        if (cycles == 20000) begin
            fail_count = fail_count + 1;
            report_and_stop();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge CLK_I);
        ADDR_I <= a;
        WDATA_I <= v;
        WR_I <= 1'b1;
        @(posedge CLK_I);
        WR_I <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge CLK_I);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge CLK_I);
        RD_I <= 1'b0;
        #1 v = RDATA_O;
    endtask

    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        rd(a, d);
        chk(d, e);
    endtask

    task automatic rst();
        @(posedge CLK_I);
        RST_I <= 1'b1;
        repeat (2) @(posedge CLK_I);
        RST_I <= 1'b0;
    endtask

    // Automatic operation; two clears because a refused go stays set
    task automatic op(input logic [1:0] m, input logic [15:0] a, input logic [7:0] v);
        wr(CT, {3'h0, m, 3'h6});
        wr(a, v);
        wr(CT, {3'h0, m, 3'h7});
        hv_cnt = 0;
        d = 8'h01;
        for (int i = 0; i < 80 && d[0] !== 1'b0; i++) rd(CT, d);
        ok = (d[0] === 1'b0);
        wr(CT, 8'h00);
        wr(CT, 8'h00);
    endtask

    // --------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------
    initial begin
        repeat (5) @(posedge CLK_I);
        RST_I <= 1'b0;
        rdc(CT, 8'h00);
        chk({7'h0, ARRAY_PWR_DOWN_O}, 8'h00);
        wr(eeprom_cfg_pkg::OFS_DIV_HI, 8'h00);
        wr(eeprom_cfg_pkg::OFS_DIV_LO, 8'h02);
        rdc(eeprom_cfg_pkg::OFS_DIV_LO, 8'h02);
        op(2'h1, eeprom_cfg_pkg::OFS_DIV_NV_HI, 8'h00);
        op(2'h1, eeprom_cfg_pkg::OFS_DIV_NV_LO, 8'h00);
        op(2'h1, OPT, 8'h00);
        op(2'h0, eeprom_cfg_pkg::OFS_DIV_NV_HI, 8'h00);
        op(2'h0, eeprom_cfg_pkg::OFS_DIV_NV_LO, 8'h03);
        chk({7'h0, hv_cnt >= T_PGM * 4 - 4 && hv_cnt <= T_PGM * 4 + 6}, 8'h01);
        op(2'h0, OPT, 8'hF0);
        rdc(OPT, 8'hF0);
        rst();
        rdc(SHD, 8'hF0);
        rdc(eeprom_cfg_pkg::OFS_DIV_LO, 8'h03);
        chk({7'h0, SECURE_O}, 8'h00);
        wr(eeprom_cfg_pkg::OFS_DIV_HI, 8'hF8);
        rdc(eeprom_cfg_pkg::OFS_DIV_HI, 8'h00);
        wr(SHD, 8'h55);
        rdc(SHD, 8'hF0);
        rdc(16'h1234, 8'h00);
        TB_CLK_SEL_I <= 1'b1;
        op(2'h1, 16'h0805, 8'h00);
        chk({7'h0, hv_cnt >= T_ERS * 3 - 3 && hv_cnt <= T_ERS * 3 + 5}, 8'h01);
        rdc(16'h0805, 8'hFF);
        TB_CLK_SEL_I <= 1'b0;
        op(2'h0, 16'h0805, 8'h0F);
        chk({7'h0, ok}, 8'h01);
        rdc(16'h0805, 8'h0F);
        wr(CT, 8'h03);
        rdc(CT, 8'h02);
        wr(CT, 8'h06);
        wr(16'h1234, 8'h00);
        wr(CT, 8'h07);
        rdc(CT, 8'h06);
        wr(CT, 8'h0C);
        wr(16'h0806, 8'h00);
        wr(CT, 8'h0D);
        repeat (40) @(posedge CLK_I);
        wr(CT, 8'h00);
        rdc(CT, 8'h0C);
        wr(CT, 8'h00);
        rdc(16'h0806, 8'hFF);
        op(2'h1, OPT, 8'h00);
        op(2'h0, OPT, 8'hF2);
        rdc(SHD, 8'hF0);
        rdc(OPT, 8'hF2);
        rdc(SHD, 8'hF2);
        op(2'h1, 16'h0880, 8'h00);
        chk({7'h0, ok}, 8'h00);
        chk(8'(hv_cnt), 8'h00);
        op(2'h1, 16'h087F, 8'h00);
        chk({7'h0, ok}, 8'h01);
        rdc(16'h087F, 8'hFF);
        op(2'h2, 16'h0805, 8'h00);
        chk({7'h0, ok}, 8'h01);
        rdc(16'h0805, 8'hFF);
        wr(CT, 8'h20);
        #1 chk({7'h0, ARRAY_PWR_DOWN_O}, 8'h01);
        rst();
        chk({7'h0, ARRAY_PWR_DOWN_O}, 8'h00);
        rdc(SHD, 8'hF2);
        op(2'h1, OPT, 8'h00);
        op(2'h0, OPT, 8'hE0);
        rst();
        chk({7'h0, SECURE_O}, 8'h01);
        op(2'h0, 16'h08F0, 8'h00);
        chk({7'h0, ok}, 8'h00);
        op(2'h0, 16'h08EF, 8'h00);
        op(2'h1, 16'h08EF, 8'h00);
        chk({7'h0, ok}, 8'h01);
        op(2'h2, 16'h0805, 8'h00);
        chk({7'h0, ok}, 8'h00);
        op(2'h3, 16'h0805, 8'h00);
        chk({7'h0, ok}, 8'h00);
        op(2'h1, OPT, 8'h00);
        chk({7'h0, ok}, 8'h00);
        rdc(OPT, 8'hE0);
        report_and_stop();
    end
endmodule
